// [rtl/xcvr_test_defines.vh]
// Purpose: Shared constants for the transceiver test-verifier and side-port logic.
// Assumes: Included by its bare name from every design file that needs it.
// Notes:   Only definitions live here; no logic.
`ifndef XCVR_TEST_DEFINES_VH
`define XCVR_TEST_DEFINES_VH

// ==========================================================================
// Verifier timing
// ==========================================================================
`define VERIF_PATTERN_WORDS 16'h007f
`define PRBS_ERR_MIN_CYCLES 2'h3
`define PRBS_TAP_HI 6
`define PRBS_TAP_LO 5

// ==========================================================================
// Reconfiguration bus layout
// ==========================================================================
`define TOGXB_WIDTH 2
`define TOGXB_OC_RESTART 0
`define TOGXB_OC_FREEZE 1
`define FROMGXB_WIDTH 5
`define FROMGXB_OC_BUSY 0
`define FROMGXB_OC_DONE 1
`define FROMGXB_CAL_DONE 2
`define FROMGXB_TEST_DONE 3
`define FROMGXB_TEST_ERR 4

// ==========================================================================
// Offset cancellation and calibration
// ==========================================================================
`define OC_TRIM_RESET 6'h20
`define OC_STEPS 6'h3f
`define CAL_TICKS 8'h10

`endif

// [rtl/pattern_checker.v]
// Purpose: Self-synchronising pseudo-random word checker for the receive verifier.
// Assumes: Words arrive on clk, oldest serial bit in the most significant position.
// Notes:   Each word is predicted from the previous one, so the checker locks after one word.
`timescale 1ns/10ps
`include "xcvr_test_defines.vh"

module pattern_checker #(
    parameter W = 8,
    parameter [15:0] PATTERN_WORDS = `VERIF_PATTERN_WORDS
) (
    input wire clk,
    input wire reset,
    input wire clear,
    input wire enable,
    input wire data_valid,
    input wire [W-1:0] data,
    output reg word_err,
    output reg cycle_done
);

    // ======================================================================
    // Prediction
    // ======================================================================
    function [W-1:0] prbs_next;
        input [W-1:0] prev;
        reg [6:0] s;
        reg nb;
        integer i;
        begin
            s = prev[6:0];
            prbs_next = {W{1'b0}};
            for (i = W - 1; i >= 0; i = i - 1) begin
                nb = s[`PRBS_TAP_HI] ^ s[`PRBS_TAP_LO];
                prbs_next[i] = nb;
                s = {s[5:0], nb};
            end
        end
    endfunction

    // ======================================================================
    // Checking
    // ======================================================================
    reg locked;
    reg [W-1:0] last;
    reg [15:0] count;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            locked <= 1'b0;
            last <= {W{1'b0}};
            count <= 16'h0000;
            word_err <= 1'b0;
            cycle_done <= 1'b0;
        end else if (clear || !enable) begin
            locked <= 1'b0;
            count <= 16'h0000;
            word_err <= 1'b0;
            cycle_done <= 1'b0;
        end else begin
            word_err <= 1'b0;
            cycle_done <= 1'b0;
            if (data_valid) begin
                last <= data;
                locked <= 1'b1;
                if (locked) begin
                    word_err <= (data != prbs_next(last));
                    if (count == PATTERN_WORDS - 16'h0001) begin
                        count <= 16'h0000;
                        cycle_done <= 1'b1;
                    end else begin
                        count <= count + 16'h0001;
                    end
                end
            end
        end
    end

endmodule

// [rtl/xcvr_test_verifier_status.v]
// Purpose: Verifier status flags, reconfiguration side ports and calibration block control.
// Assumes: clk is the recovered receive clock; receive reset and side-port pins pass two flip-flops, mode pins are used directly.
// Notes:   Slow side clocks are sampled as levels and their rising edges used as ticks.
//
// Operation
// - Self-test: done rises on full pattern cycle or error, holds until receive reset.
// - Pseudo-random test: done rises on full pattern cycle, holds until receive reset.
// - Self-test: error flag is sticky until receive reset clears it.
// - Pseudo-random test: error pulses at least 3 cycles, drops after clean sequence.
// - Reconfiguration clock steps offset cancellation, except in PCI Express interface mode.
// - Outbound reconfiguration bus is driven back to the controller as a status bus.
// - Calibration power-down input, passed through two flip-flops and applied on clk, powers down the calibration block.
`timescale 1ns/10ps
`include "xcvr_test_defines.vh"

module xcvr_test_verifier_status #(
    parameter W = 8,
    parameter [15:0] PATTERN_WORDS = `VERIF_PATTERN_WORDS
) (
    input wire clk,
    input wire reset,
    input wire rx_digitalreset,
    input wire bist_mode,
    input wire prbs_mode,
    input wire pipe_mode,
    input wire rx_data_valid,
    input wire [W-1:0] rx_data,
    input wire reconfig_clk,
    input wire offset_cmp,
    input wire [`TOGXB_WIDTH-1:0] reconfig_togxb,
    output reg [`FROMGXB_WIDTH-1:0] reconfig_fromgxb,
    input wire cal_blk_clk,
    input wire cal_blk_powerdown,
    output reg test_done,
    output reg test_err,
    output reg [5:0] offset_trim,
    output reg offset_cal_done,
    output reg cal_done,
    output reg cal_powered_down
);

    // ======================================================================
    // Synchronisers
    // ======================================================================
    // Stage one of every chain is read only by stage two.
    reg [6:0] meta;
    reg [6:0] sync;
    reg [3:0] sync_prev;
    reg [`TOGXB_WIDTH-1:0] togxb_stable;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            meta <= 7'h00;
            sync <= 7'h00;
            sync_prev <= 4'h0;
            togxb_stable <= {`TOGXB_WIDTH{1'b0}};
        end else begin
            meta <= {reconfig_togxb, cal_blk_powerdown, offset_cmp, cal_blk_clk,
                     reconfig_clk, rx_digitalreset};
            sync <= meta;
            sync_prev <= {sync[6:5], sync[2:1]};
            // A bus word is taken only once two samples agree, so bit skew cannot leak in.
            if (sync[6:5] == sync_prev[3:2]) begin
                togxb_stable <= sync[6:5];
            end
        end
    end

    wire rx_clear = sync[0];
    wire reconfig_tick = sync[1] && !sync_prev[0];
    wire cal_tick = sync[2] && !sync_prev[1];
    wire cmp_level = sync[3];
    wire cal_pd = sync[4];
    reg oc_restart_prev;
    wire oc_restart = togxb_stable[`TOGXB_OC_RESTART] && !oc_restart_prev;
    wire oc_freeze = togxb_stable[`TOGXB_OC_FREEZE];

    // ======================================================================
    // Pattern verifier
    // ======================================================================
    wire word_err;
    wire cycle_done;
    wire test_on = bist_mode || prbs_mode;

    pattern_checker #(
        .W(W),
        .PATTERN_WORDS(PATTERN_WORDS)
    ) u_checker (
        .clk(clk),
        .reset(reset),
        .clear(rx_clear),
        .enable(test_on),
        .data_valid(rx_data_valid),
        .data(rx_data),
        .word_err(word_err),
        .cycle_done(cycle_done)
    );

    // ======================================================================
    // Status flags
    // ======================================================================
    // The receive reset is a level held at least two cycles, so a synchronous clear
    // after synchronisation still lands inside it.
    reg [1:0] err_hold;
    reg seq_dirty;
    reg clean_seq_seen;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            test_done <= 1'b0;
            test_err <= 1'b0;
            err_hold <= 2'h0;
            seq_dirty <= 1'b0;
            clean_seq_seen <= 1'b0;
        end else if (rx_clear) begin
            test_done <= 1'b0;
            test_err <= 1'b0;
            err_hold <= 2'h0;
            seq_dirty <= 1'b0;
            clean_seq_seen <= 1'b0;
        end else if (bist_mode) begin
            if (cycle_done || word_err) begin
                test_done <= 1'b1;
            end
            if (word_err) begin
                test_err <= 1'b1;
            end
        end else if (prbs_mode) begin
            if (cycle_done) begin
                test_done <= 1'b1;
            end
            if (word_err) begin
                test_err <= 1'b1;
                err_hold <= `PRBS_ERR_MIN_CYCLES - 2'h1;
                seq_dirty <= 1'b1;
                clean_seq_seen <= 1'b0;
            end else begin
                if (err_hold != 2'h0) begin
                    err_hold <= err_hold - 2'h1;
                end
                if (cycle_done) begin
                    seq_dirty <= 1'b0;
                    if (!seq_dirty) begin
                        clean_seq_seen <= 1'b1;
                    end
                end
                // Drop only once the minimum width is met and a whole clean sequence passed.
                if (test_err && err_hold == 2'h0 &&
                    (clean_seq_seen || (cycle_done && !seq_dirty))) begin
                    test_err <= 1'b0;
                    clean_seq_seen <= 1'b0;
                end
            end
        end
    end

    // ======================================================================
    // Offset cancellation
    // ======================================================================
    localparam [2:0] OC_IDLE = 3'b001;
    localparam [2:0] OC_RUN = 3'b010;
    localparam [2:0] OC_DONE = 3'b100;
    reg [2:0] oc_state;
    reg [5:0] oc_steps;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            oc_state <= OC_IDLE;
            oc_steps <= 6'h00;
            offset_trim <= `OC_TRIM_RESET;
            offset_cal_done <= 1'b0;
            oc_restart_prev <= 1'b0;
        end else begin
            oc_restart_prev <= togxb_stable[`TOGXB_OC_RESTART];
            if (pipe_mode) begin
                // No cancellation runs in this mode, so the trim sits at mid-scale.
                oc_state <= OC_IDLE;
                oc_steps <= 6'h00;
                offset_trim <= `OC_TRIM_RESET;
                offset_cal_done <= 1'b0;
            end else begin
                case (oc_state)
                    OC_IDLE: begin
                        oc_steps <= 6'h00;
                        offset_cal_done <= 1'b0;
                        oc_state <= OC_RUN;
                    end
                    OC_RUN: begin
                        if (reconfig_tick && !oc_freeze) begin
                            if (cmp_level && offset_trim != 6'h00) begin
                                offset_trim <= offset_trim - 6'h01;
                            end else if (!cmp_level && offset_trim != 6'h3f) begin
                                offset_trim <= offset_trim + 6'h01;
                            end
                            oc_steps <= oc_steps + 6'h01;
                            if (oc_steps == `OC_STEPS - 6'h01) begin
                                oc_state <= OC_DONE;
                                offset_cal_done <= 1'b1;
                            end
                        end
                    end
                    OC_DONE: begin
                        if (oc_restart) begin
                            oc_state <= OC_IDLE;
                            offset_cal_done <= 1'b0;
                        end
                    end
                    default: begin
                        oc_state <= OC_IDLE;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // Calibration block
    // ======================================================================
    localparam [2:0] CAL_OFF = 3'b001;
    localparam [2:0] CAL_RUN = 3'b010;
    localparam [2:0] CAL_DONE = 3'b100;
    reg [2:0] cal_state;
    reg [7:0] cal_count;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cal_state <= CAL_OFF;
            cal_count <= 8'h00;
            cal_done <= 1'b0;
            cal_powered_down <= 1'b1;
        end else if (cal_pd) begin
            cal_state <= CAL_OFF;
            cal_count <= 8'h00;
            cal_done <= 1'b0;
            cal_powered_down <= 1'b1;
        end else begin
            cal_powered_down <= 1'b0;
            case (cal_state)
                CAL_OFF: begin
                    cal_count <= 8'h00;
                    cal_state <= CAL_RUN;
                end
                CAL_RUN: begin
                    // Progress is paced only by the calibration clock.
                    if (cal_tick) begin
                        cal_count <= cal_count + 8'h01;
                        if (cal_count == `CAL_TICKS - 8'h01) begin
                            cal_state <= CAL_DONE;
                            cal_done <= 1'b1;
                        end
                    end
                end
                CAL_DONE: begin
                    cal_done <= 1'b1;
                end
                default: begin
                    cal_state <= CAL_OFF;
                end
            endcase
        end
    end

    // ======================================================================
    // Outbound reconfiguration bus
    // ======================================================================
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            reconfig_fromgxb <= {`FROMGXB_WIDTH{1'b0}};
        end else begin
            reconfig_fromgxb[`FROMGXB_OC_BUSY] <= (oc_state == OC_RUN);
            reconfig_fromgxb[`FROMGXB_OC_DONE] <= offset_cal_done;
            reconfig_fromgxb[`FROMGXB_CAL_DONE] <= cal_done;
            reconfig_fromgxb[`FROMGXB_TEST_DONE] <= test_done;
            reconfig_fromgxb[`FROMGXB_TEST_ERR] <= test_err;
        end
    end

endmodule

// [dv/fabric_stub.sv]
// Purpose: Far-side model: fabric sending pattern words plus slow side clocks.
// Assumes: Driven from the recovered receive clock; words are MSB-first serial order.
// Notes:   corrupt flips one bit of the word sent in that cycle.
`timescale 1ns/10ps

module fabric_stub (
    input wire clk,
    input wire reset,
    input wire send,
    input wire corrupt,
    input wire slow_run,
    output reg rx_data_valid,
    output reg [7:0] rx_data,
    output reg reconfig_clk,
    output reg cal_blk_clk
);
    reg [6:0] lfsr;
    reg [6:0] nxt;
    reg [7:0] word;
    reg [2:0] div;
    integer i;
    // ======================================================================
    // Pattern source and side clocks
    // ======================================================================
    // The low seven bits of each word are the seed of the next one.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            lfsr <= 7'h7f;
            div <= 3'h0;
            rx_data_valid <= 1'b0;
            rx_data <= 8'h00;
            reconfig_clk <= 1'b0;
            cal_blk_clk <= 1'b0;
        end else begin
            nxt = lfsr;
            for (i = 0; i < 8; i = i + 1) begin
                word = {word[6:0], nxt[6] ^ nxt[5]};
                nxt = {nxt[5:0], nxt[6] ^ nxt[5]};
            end
            rx_data_valid <= send;
            if (send) begin
                lfsr <= nxt;
                rx_data <= corrupt ? word ^ 8'h01 : word;
            end else begin
                // An idle line must not look like a repeat of the last word.
                rx_data <= ~rx_data;
            end
            if (slow_run) begin
                div <= div + 3'h1;
                reconfig_clk <= div[2];
                cal_blk_clk <= ~div[2];
            end
        end
    end
endmodule

// [dv/xcvr_status_asserts.sv]
// Purpose: Port-level checks of verifier flags, side buses and calibration control.
// Assumes: Bound to the top module; one clock domain.
// Notes:   quiet marks that receive reset has been low long enough to stop acting.
`timescale 1ns/10ps
`include "xcvr_test_defines.vh"

module xcvr_status_checker #(
    parameter W = 8,
    parameter [15:0] PATTERN_WORDS = `VERIF_PATTERN_WORDS
) (
    input wire clk,
    input wire reset,
    input wire rx_digitalreset,
    input wire bist_mode,
    input wire prbs_mode,
    input wire pipe_mode,
    input wire rx_data_valid,
    input wire [W-1:0] rx_data,
    input wire reconfig_clk,
    input wire offset_cmp,
    input wire [`TOGXB_WIDTH-1:0] reconfig_togxb,
    input wire [`FROMGXB_WIDTH-1:0] reconfig_fromgxb,
    input wire cal_blk_clk,
    input wire cal_blk_powerdown,
    input wire test_done,
    input wire test_err,
    input wire [5:0] offset_trim,
    input wire offset_cal_done,
    input wire cal_done,
    input wire cal_powered_down
);
    reg [2:0] quiet_cnt;
    wire quiet = quiet_cnt >= 3'h4;
    always @(posedge clk or posedge reset) begin
        if (reset)
            quiet_cnt <= 3'h0;
        else if (rx_digitalreset)
            quiet_cnt <= 3'h0;
        else if (quiet_cnt != 3'h7)
            quiet_cnt <= quiet_cnt + 3'h1;
    end
    // ======================================================================
    // Properties
    // ======================================================================
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    done_hold_a: assert property (test_done && quiet && !rx_digitalreset |=> test_done)
        else $error("test done dropped without receive reset");
    err_sticky_a: assert property (bist_mode && test_err && quiet && !rx_digitalreset
        |=> test_err || !bist_mode) else $error("self-test error flag not sticky");
    err_min_a: assert property ($rose(test_err) && prbs_mode && !bist_mode && quiet
        |-> test_err [*3]) else $error("pattern error pulse shorter than three cycles");
    flag_clear_a: assert property (rx_digitalreset [*2] |-> ##2 (!test_done && !test_err))
        else $error("receive reset did not clear flags");
    freeze_hold_a: assert property ((reconfig_togxb[`TOGXB_OC_FREEZE] && !pipe_mode) [*6]
        |-> $stable(offset_trim)) else $error("offset trim moved while frozen");
    done_cause_a: assert property ($rose(test_done)
        |-> $past(rx_data_valid, 2) || $past(rx_data_valid, 3))
        else $error("test done rose without received words");
    status_mirror_a: assert property (reconfig_fromgxb[3] == $past(test_done)
        && reconfig_fromgxb[4] == $past(test_err)) else $error("status bus test bits wrong");
    cal_mirror_a: assert property (reconfig_fromgxb[2] == $past(cal_done)
        && reconfig_fromgxb[1] == $past(offset_cal_done)) else $error("status bus cal bits wrong");
    pipe_idle_a: assert property (pipe_mode [*2]
        |-> offset_trim == `OC_TRIM_RESET && !offset_cal_done)
        else $error("offset cancellation active in PCI Express mode");
    trim_step_a: assert property ($changed(offset_trim)
        |-> offset_trim == $past(offset_trim) + 6'h01 || offset_trim == $past(offset_trim) - 6'h01
        || offset_trim == `OC_TRIM_RESET) else $error("offset trim jumped");
    cal_off_a: assert property (cal_blk_powerdown [*4] |-> cal_powered_down && !cal_done)
        else $error("calibration not powered down");
    cal_rise_a: assert property ($rose(cal_done) |-> !cal_powered_down)
        else $error("calibration done while powered down");
endmodule

bind xcvr_test_verifier_status xcvr_status_checker #(.W(W), .PATTERN_WORDS(PATTERN_WORDS)) chk (
    .clk(clk), .reset(reset), .rx_digitalreset(rx_digitalreset), .bist_mode(bist_mode),
    .prbs_mode(prbs_mode), .pipe_mode(pipe_mode), .rx_data_valid(rx_data_valid),
    .rx_data(rx_data), .reconfig_clk(reconfig_clk), .offset_cmp(offset_cmp),
    .reconfig_togxb(reconfig_togxb), .reconfig_fromgxb(reconfig_fromgxb),
    .cal_blk_clk(cal_blk_clk), .cal_blk_powerdown(cal_blk_powerdown), .test_done(test_done),
    .test_err(test_err), .offset_trim(offset_trim), .offset_cal_done(offset_cal_done),
    .cal_done(cal_done), .cal_powered_down(cal_powered_down));

// [dv/test_xcvr_test_verifier_status.sv]
// Purpose: Directed regression of verifier flags, offset cancellation and calibration.
// Assumes: Pattern length shortened to 8 words to keep the run brief.
// Notes:   Offset cancellation and calibration run in the background from reset release.
`timescale 1ns/10ps
`include "xcvr_test_defines.vh"

module test_xcvr_test_verifier_status;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic rx_digitalreset = 1'b0;
    logic bist_mode = 1'b0;
    logic prbs_mode = 1'b0;
    logic pipe_mode = 1'b0;
    logic offset_cmp = 1'b1;
    logic [1:0] reconfig_togxb = 2'h0;
    logic cal_blk_powerdown = 1'b0;
    logic send = 1'b0;
    logic corrupt = 1'b0;
    wire rx_data_valid, reconfig_clk, cal_blk_clk, test_done, test_err;
    wire offset_cal_done, cal_done, cal_powered_down;
    wire [7:0] rx_data;
    wire [4:0] reconfig_fromgxb;
    wire [5:0] offset_trim;
    int n_errors = 0;
    int samples_checked = 0;

    initial forever #12.5 clk = ~clk;

    fabric_stub far (.clk(clk), .reset(reset), .send(send), .corrupt(corrupt),
        .slow_run(1'b1), .rx_data_valid(rx_data_valid), .rx_data(rx_data),
        .reconfig_clk(reconfig_clk), .cal_blk_clk(cal_blk_clk));

    xcvr_test_verifier_status #(.W(8), .PATTERN_WORDS(16'h0008)) dut (.clk(clk), .reset(reset),
        .rx_digitalreset(rx_digitalreset), .bist_mode(bist_mode), .prbs_mode(prbs_mode),
        .pipe_mode(pipe_mode), .rx_data_valid(rx_data_valid), .rx_data(rx_data),
        .reconfig_clk(reconfig_clk), .offset_cmp(offset_cmp), .reconfig_togxb(reconfig_togxb),
        .reconfig_fromgxb(reconfig_fromgxb), .cal_blk_clk(cal_blk_clk),
        .cal_blk_powerdown(cal_blk_powerdown), .test_done(test_done), .test_err(test_err),
        .offset_trim(offset_trim), .offset_cal_done(offset_cal_done), .cal_done(cal_done),
        .cal_powered_down(cal_powered_down));

    // ======================================================================
    // Tasks
    // ======================================================================
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task check_trim(input logic [5:0] got, input logic [5:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL at %0t: trim %h expected %h", $time, got, exp);
        end
    endtask

    function logic sel(input int w);
        case (w)
            0: sel = test_done;
            1: sel = test_err;
            3: sel = cal_done;
            default: sel = offset_cal_done;
        endcase
    endfunction

    // Bounded wait; the following compare reports a wait that ran out.
    task wait_for(input int w, input int limit);
        for (int i = 0; i < limit && sel(w) !== 1'b1; i++) cyc(1);
    endtask

    task verifier(input logic b, input logic p, input logic bad);
        bist_mode <= b;
        prbs_mode <= p;
        send <= 1'b1;
        cyc(4);
        corrupt <= bad;
        cyc(1);
        corrupt <= 1'b0;
        if (bad) begin
            wait_for(1, 10);
            check_bit(test_err, 1'b1);
        end
        wait_for(0, 60);
        cyc(60);
        check_bit(test_done, 1'b1);
        check_bit(test_err, bad & b);
        check_bit(reconfig_fromgxb[`FROMGXB_TEST_DONE], 1'b1);
        send <= 1'b0;
        cyc(4);
        check_bit(test_done, 1'b1);
        // Held for the shortest width the receive reset is allowed.
        rx_digitalreset <= 1'b1;
        cyc(2);
        rx_digitalreset <= 1'b0;
        cyc(4);
        check_bit(test_done, 1'b0);
        check_bit(test_err, 1'b0);
    endtask

    task report_and_stop;
        $display("checks %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ======================================================================
    // Sequence
    // ======================================================================
    initial begin
        cyc(15);
        check_trim(offset_trim, `OC_TRIM_RESET);
        check_bit(cal_powered_down, 1'b1);
        cyc(1);
        reset <= 1'b0;
        cyc(4);
        verifier(1'b1, 1'b0, 1'b0);
        verifier(1'b1, 1'b0, 1'b1);
        verifier(1'b0, 1'b1, 1'b0);
        verifier(1'b0, 1'b1, 1'b1);
        check_bit(cal_done, 1'b1);
        cal_blk_powerdown <= 1'b1;
        cyc(6);
        check_bit(cal_powered_down, 1'b1);
        check_bit(cal_done, 1'b0);
        cal_blk_powerdown <= 1'b0;
        wait_for(3, 400);
        check_bit(cal_done, 1'b1);
        wait_for(4, 1200);
        check_trim(offset_trim, 6'h00);
        offset_cmp <= 1'b0;
        reconfig_togxb <= 2'h1;
        cyc(4);
        reconfig_togxb <= 2'h0;
        cyc(8);
        check_bit(offset_cal_done, 1'b0);
        check_bit(reconfig_fromgxb[`FROMGXB_OC_BUSY], 1'b1);
        wait_for(4, 1200);
        check_trim(offset_trim, 6'h3f);
        pipe_mode <= 1'b1;
        reconfig_togxb <= 2'h2;
        cyc(5);
        check_trim(offset_trim, `OC_TRIM_RESET);
        check_bit(offset_cal_done, 1'b0);
        pipe_mode <= 1'b0;
        // Freeze is already settled, so the restarted run must not step the trim.
        cyc(40);
        check_trim(offset_trim, `OC_TRIM_RESET);
        reconfig_togxb <= 2'h0;
        report_and_stop;
    end

    initial begin
        cyc(20000);
        n_errors++;
        report_and_stop;
    end
endmodule
